// ### inc/uart_flow_params.svh
`ifndef UART_FLOW_PARAMS_SVH
`define UART_FLOW_PARAMS_SVH
`define FIFO_DEPTH 64
`define A_IER 7'h00
`define A_IIR 7'h04
`define A_FCR 7'h08
`define A_LCR 7'h0C
`define A_MCR 7'h10
`define A_LSR 7'h14
`define A_MSR 7'h18
`define A_EFR 7'h1C
`define A_TCR 7'h20
`define A_TLR 7'h24
`define A_TXLVL 7'h28
`define A_RXLVL 7'h2C
`define A_XON1 7'h30
`define A_XON2 7'h34
`define A_XOFF1 7'h38
`define A_XOFF2 7'h3C
`define A_SPR 7'h40
`define A_DLL 7'h44
`define A_DLH 7'h48
`define A_XFR 7'h4C
`define A_SRST 7'h50
`define IIR_RST 8'h01
`define IIR_MODEM 8'h00
`define IIR_XOFF 8'h10
`define LCR_RST 8'h1D
`define LSR_RST 8'h60
`define SRST_BIT 3
`define IER_MODEM 3
`define IER_XOFF 5
`define MCR_RTS 1
`define MCR_XANY 5
`define EFR_SPEC 5
`define EFR_ARTS 6
`define EFR_ACTS 7
`define TCR_STEP 4
`define RXTRIG0 8
`define RXTRIG1 16
`define RXTRIG2 56
`define RXTRIG3 60
`define RXRES0 0
`define WL_BASE 5
`endif

// ### inc/uart_flow_pkg.sv
package uart_flow_pkg;
	typedef enum logic [1:0] {
		FL_IDLE = 2'b00,
		FL_FIRST = 2'b01,
		FL_SECOND = 2'b10
	} flow_state_t;
endpackage

// ### inc/match_if.sv
`timescale 1ns/1ns
`default_nettype none
interface match_if;
	logic rx_valid;
	logic [7:0] rx_char;
	logic [1:0] rx_cmp;
	logic tx_one;
	logic spec_en;
	logic [7:0] xon1, xon2, xoff1, xoff2, wmask;
	logic xoff_hit, xon_hit, spec_hit, any_char;
	modport ctrl(output rx_valid, rx_char, rx_cmp, tx_one, spec_en,
		xon1, xon2, xoff1, xoff2, wmask,
		input xoff_hit, xon_hit, spec_hit, any_char);
	modport matcher(input rx_valid, rx_char, rx_cmp, tx_one, spec_en,
		xon1, xon2, xoff1, xoff2, wmask,
		output xoff_hit, xon_hit, spec_hit, any_char);
endinterface
`default_nettype wire

// ### rtl/flow_match.sv
`timescale 1ns/1ns
`default_nettype none
module flow_match (
	input wire logic sys_clk,
	input wire logic srst,
	match_if.matcher m
);
	logic [7:0] ch;
	logic one, either, both;
	logic off_pend_r, on_pend_r;
	logic off_a, off_b, on_a, on_b;

	// compare only the bits the word length carries
	assign ch = m.rx_char & m.wmask;
	assign off_a = ch == (m.xoff1 & m.wmask);
	assign off_b = ch == (m.xoff2 & m.wmask);
	assign on_a = ch == (m.xon1 & m.wmask);
	assign on_b = ch == (m.xon2 & m.wmask);
	assign either = (m.rx_cmp == 2'b11) && m.tx_one;
	assign both = (m.rx_cmp == 2'b11) && !m.tx_one;
	assign one = m.rx_cmp == 2'b10;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			off_pend_r <= 1'b0;
			on_pend_r <= 1'b0;
		end else if (m.rx_valid) begin
			off_pend_r <= both && off_a;
			on_pend_r <= both && on_a;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			m.xoff_hit <= 1'b0;
			m.xon_hit <= 1'b0;
			m.spec_hit <= 1'b0;
			m.any_char <= 1'b0;
		end else begin
			m.any_char <= m.rx_valid;
			m.spec_hit <= m.rx_valid && m.spec_en && off_b;
			m.xoff_hit <= m.rx_valid && ((one && off_a) ||
				(m.rx_cmp == 2'b01 && off_b) ||
				(either && (off_a || off_b)) ||
				(both && off_pend_r && off_b));
			m.xon_hit <= m.rx_valid && ((one && on_a) ||
				(m.rx_cmp == 2'b01 && on_b) ||
				(either && (on_a || on_b)) ||
				(both && on_pend_r && on_b));
		end
	end
endmodule
`default_nettype wire

// ### rtl/uart_flow_ctrl.sv
// The Avalon-MM slave port and the address map were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "uart_flow_params.svh"
module uart_flow_ctrl
	import uart_flow_pkg::*;
#(
	parameter int FIFO_DEPTH = `FIFO_DEPTH,
	parameter int LVL_W = $clog2(FIFO_DEPTH) + 1
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [6:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic cts_n,
	input wire logic rx_valid,
	input wire logic [7:0] rx_char,
	input wire logic [LVL_W-1:0] rx_level,
	input wire logic [LVL_W-1:0] tx_level,
	input wire logic tx_flow_ack,
	output logic rts_n,
	output logic irq_n,
	output logic tx_permit,
	output logic tx_flow_req,
	output logic [7:0] tx_flow_char,
	output logic dp_reset,
	output logic [7:0] line_ctrl,
	output logic [15:0] divisor
);
	initial begin
		if (FIFO_DEPTH < `RXTRIG3 + 1 || LVL_W != $clog2(FIFO_DEPTH) + 1)
			$error("fifo depth or level width unusable");
	end

	logic srst, soft_rst_r, wait_r, acc, acc_rd, acc_wr;
	logic [7:0] ier_r, fcr_r, mcr_r, efr_r, tcr_r, tlr_r, xfr_r;
	logic [7:0] lcr_r, lsr_r, msr_lo_r, spr_r, dll_r, dlh_r;
	logic [7:0] xon1_r, xon2_r, xoff1_r, xoff2_r, interrupt_ident_reg, modem_status_reg, wd;
	logic [LVL_W-1:0] halt_lvl, res_lvl, tx_space;
	logic cts_s1_r, cts_s2_r, cts_s3_r, cts_q_r, cts_act;
	logic rts_halt_r, sw_halt_r, xoff_int_r, xoff_spec_r, sent_off_r;
	logic modem_pend, xoff_pend, pend, auto_rts, auto_cts;
	logic xoff_need, xon_need, iir_rd, msr_rd;
	logic [7:0] wmask, first_ch, second_ch;
	logic load_off_r;
	flow_state_t fl_r;
	match_if mi();

	// software reset shares the hardware reset path
	assign srst = !rst_n || soft_rst_r;
	assign acc = (avs_read || avs_write) && !wait_r;
	assign acc_rd = acc && avs_read;
	assign acc_wr = acc && avs_write;
	assign wd = avs_writedata[7:0];
	assign iir_rd = acc_rd && avs_address == `A_IIR;
	assign msr_rd = acc_rd && avs_address == `A_MSR;
	assign auto_rts = efr_r[`EFR_ARTS];
	assign auto_cts = efr_r[`EFR_ACTS];

	// one wait state: the answer is built while waitrequest is high
	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			wait_r <= 1'b1;
		else
			wait_r <= !((avs_read || avs_write) && wait_r);
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			soft_rst_r <= 1'b0;
		else
			soft_rst_r <= acc_wr && avs_address == `A_SRST &&
				wd[`SRST_BIT];
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ier_r <= 8'h00;
			fcr_r <= 8'h00;
			mcr_r <= 8'h00;
			efr_r <= 8'h00;
			tcr_r <= 8'h00;
			tlr_r <= 8'h00;
			xfr_r <= 8'h00;
			lcr_r <= `LCR_RST;
		end else if (acc_wr) begin
			case (avs_address)
				`A_IER: ier_r <= wd;
				`A_FCR: fcr_r <= wd;
				`A_LCR: lcr_r <= wd;
				`A_MCR: mcr_r <= wd;
				`A_EFR: efr_r <= wd;
				`A_TCR: tcr_r <= wd;
				`A_TLR: tlr_r <= wd;
				`A_XFR: xfr_r <= wd;
				default: ;
			endcase
		end
	end

	// kept through every reset, so no reset branch
	always_ff @(posedge sys_clk) begin
		if (acc_wr) begin
			case (avs_address)
				`A_SPR: spr_r <= wd;
				`A_DLL: dll_r <= wd;
				`A_DLH: dlh_r <= wd;
				`A_XON1: xon1_r <= wd;
				`A_XON2: xon2_r <= wd;
				`A_XOFF1: xoff1_r <= wd;
				`A_XOFF2: xoff2_r <= wd;
				default: ;
			endcase
		end
	end

	// cts pin: a change counts once stages two and three agree
	always_ff @(posedge sys_clk) begin
		cts_s1_r <= cts_n;
		cts_s2_r <= cts_s1_r;
		cts_s3_r <= cts_s2_r;
	end

	// no reset: tracks the pin through reset, so no false edge after it
	always_ff @(posedge sys_clk) begin
		if (cts_s2_r == cts_s3_r)
			cts_q_r <= cts_s3_r;
	end
	assign cts_act = !cts_q_r;

	always_ff @(posedge sys_clk) begin
		if (srst)
			msr_lo_r <= 8'h00;
		else if (cts_s2_r == cts_s3_r && cts_s3_r != cts_q_r)
			msr_lo_r[0] <= 1'b1;
		else if (msr_rd)
			msr_lo_r[0] <= 1'b0;
	end
	assign modem_status_reg = {3'b000, cts_act, msr_lo_r[3:0]};

	always_ff @(posedge sys_clk) begin
		if (srst)
			lsr_r <= `LSR_RST;
		else
			lsr_r <= {1'b0, {2{tx_level == '0}}, 5'b00000};
	end

	// thresholds; zero flow threshold falls back to fifo control levels
	always_comb begin
		unique case (fcr_r[7:6])
			2'b00: begin
				halt_lvl = LVL_W'(`RXTRIG0);
				res_lvl = LVL_W'(`RXRES0);
			end
			2'b01: begin
				halt_lvl = LVL_W'(`RXTRIG1);
				res_lvl = LVL_W'(`RXTRIG0);
			end
			2'b10: begin
				halt_lvl = LVL_W'(`RXTRIG2);
				res_lvl = LVL_W'(`RXTRIG1);
			end
			2'b11: begin
				halt_lvl = LVL_W'(`RXTRIG3);
				res_lvl = LVL_W'(`RXTRIG2);
			end
		endcase
		if (tcr_r != 8'h00) begin
			halt_lvl = LVL_W'(tcr_r[3:0]) * LVL_W'(`TCR_STEP);
			res_lvl = LVL_W'(tcr_r[7:4]) * LVL_W'(`TCR_STEP);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst)
			rts_halt_r <= 1'b0;
		else if (rx_level >= halt_lvl)
			rts_halt_r <= 1'b1;
		else if (rx_level <= res_lvl)
			rts_halt_r <= 1'b0;
	end

	always_ff @(posedge sys_clk) begin
		if (srst)
			rts_n <= 1'b1;
		else if (auto_rts)
			rts_n <= rx_level >= halt_lvl ||
				(rts_halt_r && rx_level > res_lvl);
		else
			rts_n <= !mcr_r[`MCR_RTS];
	end

	// receive-side recognition lives in the matcher
	assign wmask = 8'hFF >> (2'd3 - lcr_r[1:0]);
	assign mi.rx_valid = rx_valid;
	assign mi.rx_char = rx_char;
	assign mi.rx_cmp = efr_r[1:0];
	assign mi.tx_one = efr_r[3] ^ efr_r[2];
	assign mi.spec_en = efr_r[`EFR_SPEC];
	assign mi.xon1 = xon1_r;
	assign mi.xon2 = xon2_r;
	assign mi.xoff1 = xoff1_r;
	assign mi.xoff2 = xoff2_r;
	assign mi.wmask = wmask;

	flow_match u_match (
		.sys_clk(sys_clk),
		.srst(srst),
		.m(mi)
	);

	// halting is checked only before the next start, so the
	// character in the shifter always completes
	always_ff @(posedge sys_clk) begin
		if (srst)
			sw_halt_r <= 1'b0;
		else if (mi.xoff_hit)
			sw_halt_r <= 1'b1;
		else if (mi.xon_hit ||
			(mcr_r[`MCR_XANY] && mi.any_char && sw_halt_r))
			sw_halt_r <= 1'b0;
	end

	// set beats clear when both land in one cycle
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			xoff_int_r <= 1'b0;
			xoff_spec_r <= 1'b0;
		end else if ((mi.xoff_hit || mi.spec_hit) && ier_r[`IER_XOFF]) begin
			xoff_int_r <= 1'b1;
			xoff_spec_r <= !mi.xoff_hit;
		end else if ((!xoff_spec_r && mi.xon_hit) ||
			(xoff_spec_r && iir_rd)) begin
			xoff_int_r <= 1'b0;
		end
	end

	// auto cts holds back the start of the next character; the remote
	// must drop cts by mid last stop bit for this to take effect
	always_ff @(posedge sys_clk) begin
		if (srst)
			tx_permit <= 1'b1;
		else
			tx_permit <= !(auto_cts && !cts_act) &&
				!sw_halt_r;
	end

	assign modem_pend = ier_r[`IER_MODEM] && msr_lo_r[0] &&
		!auto_cts;
	assign xoff_pend = xoff_int_r;
	assign pend = modem_pend || xoff_pend;
	always_comb begin
		interrupt_ident_reg = `IIR_RST;
		if (modem_pend)
			interrupt_ident_reg = `IIR_MODEM;
		else if (xoff_pend)
			interrupt_ident_reg = `IIR_XOFF;
	end

	always_ff @(posedge sys_clk) begin
		if (srst)
			irq_n <= 1'b1;
		else
			irq_n <= !pend;
	end

	// transmit side: one or two flow characters per event
	assign xoff_need = efr_r[3:2] != 2'b00 && !sent_off_r &&
		rx_level > halt_lvl;
	assign xon_need = sent_off_r && rx_level <= res_lvl;
	always_comb begin
		first_ch = efr_r[3] ? xoff1_r : xoff2_r;
		second_ch = xoff2_r;
		if (!load_off_r) begin
			first_ch = efr_r[3] ? xon1_r : xon2_r;
			second_ch = xon2_r;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			fl_r <= FL_IDLE;
			sent_off_r <= 1'b0;
			load_off_r <= 1'b0;
		end else begin
			unique case (fl_r)
				FL_IDLE: begin
					if (xoff_need || xon_need) begin
						fl_r <= FL_FIRST;
						load_off_r <= xoff_need;
						sent_off_r <= xoff_need;
					end
				end
				FL_FIRST: begin
					if (tx_flow_ack)
						fl_r <= (efr_r[3:2] == 2'b11) ?
							FL_SECOND : FL_IDLE;
				end
				FL_SECOND: begin
					if (tx_flow_ack)
						fl_r <= FL_IDLE;
				end
				default: fl_r <= FL_IDLE;
			endcase
		end
	end

	// masked char goes to the normal shifter, so framing matches data
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			tx_flow_req <= 1'b0;
			tx_flow_char <= 8'h00;
		end else begin
			tx_flow_req <= (fl_r == FL_FIRST || fl_r == FL_SECOND) &&
				!tx_flow_ack;
			tx_flow_char <= ((fl_r == FL_SECOND) ? second_ch :
				first_ch) & wmask;
		end
	end

	assign tx_space = LVL_W'(FIFO_DEPTH) - tx_level;
	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			avs_readdata <= 32'h0000_0000;
		else if ((avs_read || avs_write) && wait_r) begin
			avs_readdata <= 32'h0000_0000;
			case (avs_address)
				`A_IER: avs_readdata[7:0] <= ier_r;
				`A_IIR: avs_readdata[7:0] <= interrupt_ident_reg;
				`A_FCR: avs_readdata[7:0] <= fcr_r;
				`A_LCR: avs_readdata[7:0] <= lcr_r;
				`A_MCR: avs_readdata[7:0] <= mcr_r;
				`A_LSR: avs_readdata[7:0] <= lsr_r;
				`A_MSR: avs_readdata[7:0] <= modem_status_reg;
				`A_EFR: avs_readdata[7:0] <= efr_r;
				`A_TCR: avs_readdata[7:0] <= tcr_r;
				`A_TLR: avs_readdata[7:0] <= tlr_r;
				`A_TXLVL: avs_readdata[LVL_W-1:0] <= tx_space;
				`A_RXLVL: avs_readdata[LVL_W-1:0] <= rx_level;
				`A_XON1: avs_readdata[7:0] <= xon1_r;
				`A_XON2: avs_readdata[7:0] <= xon2_r;
				`A_XOFF1: avs_readdata[7:0] <= xoff1_r;
				`A_XOFF2: avs_readdata[7:0] <= xoff2_r;
				`A_SPR: avs_readdata[7:0] <= spr_r;
				`A_DLL: avs_readdata[7:0] <= dll_r;
				`A_DLH: avs_readdata[7:0] <= dlh_r;
				`A_XFR: avs_readdata[7:0] <= xfr_r;
				default: ;
			endcase
		end
	end

	assign avs_waitrequest = wait_r;
	assign line_ctrl = lcr_r;
	assign divisor = {dlh_r, dll_r};

	// datapath reset clears fifo pointers and holds tx line high
	always_ff @(posedge sys_clk) begin
		dp_reset <= srst;
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);

	sequence s_req_wait;
		(avs_read || avs_write) && wait_r;
	endsequence
	sequence s_answer;
		!wait_r ##1 wait_r;
	endsequence

	chk_rts_halt_drop: assert property (
		auto_rts && rx_level >= halt_lvl |=> rts_n)
		else $error("rts not dropped at halt level");
	chk_rts_resume_up: assert property (
		auto_rts && rx_level <= res_lvl && rx_level < halt_lvl
		|=> !rts_n)
		else $error("rts not restored at resume level");
	chk_cts_gate_tx: assert property (
		auto_cts && !cts_act |=> !tx_permit)
		else $error("transmit allowed with cts inactive");
	chk_xoff_halt_tx: assert property (
		mi.xoff_hit |=> sw_halt_r ##1 !tx_permit)
		else $error("xoff did not halt transmit");
	chk_spec_iir_clear: assert property (
		xoff_int_r && xoff_spec_r && iir_rd && !mi.spec_hit &&
		!mi.xoff_hit |=> !xoff_int_r)
		else $error("special flag not cleared by ident read");
	chk_xoff_irq_low: assert property (
		mi.xoff_hit && ier_r[`IER_XOFF] |=> ##1 !irq_n)
		else $error("xoff did not pull irq low");
	chk_bus_one_wait: assert property (
		s_req_wait |=> s_answer)
		else $error("bus answer timing broken");
	chk_flow_char_mask: assert property (
		tx_flow_req |-> (tx_flow_char & ~wmask) == 8'h00)
		else $error("flow char exceeds word length");
	chk_reset_values: assert property (
		disable iff (1'b0) !rst_n |=> lcr_r == `LCR_RST && rts_n &&
		irq_n && lsr_r == `LSR_RST)
		else $error("reset values wrong");
endmodule
`default_nettype wire

// ### tb/far_end_model.sv
`timescale 1ns/1ns
`default_nettype none
module far_end_model (
	input wire logic sys_clk,
	input wire logic tx_flow_req,
	input wire logic [7:0] tx_flow_char,
	output logic tx_flow_ack,
	output logic rx_valid,
	output logic [7:0] rx_char,
	output logic cts_n
);
	logic [7:0] sent_q[$];
	int ack_delay = 0;
	int cnt = 0;
	int hold = 0;
	initial begin
		tx_flow_ack = 1'b0;
		rx_valid = 1'b0;
		rx_char = 8'h00;
		cts_n = 1'b0;
	end
	// hold-off lets req fall before the next char is taken
	always @(posedge sys_clk) begin
		tx_flow_ack <= 1'b0;
		if (hold > 0) begin
			hold <= hold - 1;
		end else if (tx_flow_req === 1'b1) begin
			if (cnt >= ack_delay) begin
				tx_flow_ack <= 1'b1;
				sent_q.push_back(tx_flow_char);
				cnt <= 0;
				hold <= 3;
			end else begin
				cnt <= cnt + 1;
			end
		end
	end
	task automatic send(input logic [7:0] ch);
		rx_char <= ch;
		rx_valid <= 1'b1;
		@(posedge sys_clk);
		rx_valid <= 1'b0;
		// stale byte inverted so a late sample cannot match
		rx_char <= ~ch;
		@(posedge sys_clk);
	endtask
	// cts only moves between characters
	task automatic set_cts(input logic v);
		cts_n <= v;
		@(posedge sys_clk);
	endtask
endmodule
`default_nettype wire

// ### tb/uart_flow_control_and_reset_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "uart_flow_params.svh"
module uart_flow_control_and_reset_tb_top;
	logic sys_clk, rst_n, avs_read, avs_write, cts_n, rx_valid;
	logic tx_flow_ack, avs_waitrequest, rts_n, irq_n, tx_permit;
	logic tx_flow_req, dp_reset;
	logic [6:0] avs_address, rx_level, tx_level;
	logic [31:0] avs_writedata, avs_readdata;
	logic [7:0] rx_char, tx_flow_char, line_ctrl, q;
	logic [15:0] divisor;
	int n_fail = 0;
	int checks = 0;
	int cyc = 0;
	int dp_cnt = 0;
	uart_flow_ctrl dut (.sys_clk, .rst_n, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
		.cts_n, .rx_valid, .rx_char, .rx_level, .tx_level, .tx_flow_ack,
		.rts_n, .irq_n, .tx_permit, .tx_flow_req, .tx_flow_char,
		.dp_reset, .line_ctrl, .divisor);
	far_end_model far (.sys_clk, .tx_flow_req, .tx_flow_char,
		.tx_flow_ack, .rx_valid, .rx_char, .cts_n);
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	task automatic end_of_test();
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// ceiling well above the several hundred cycles the run needs
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (dp_reset === 1'b1) dp_cnt <= dp_cnt + 1;
		if (cyc == 20000) begin
			n_fail++;
			end_of_test();
		end
	end
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			n_fail++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge sys_clk);
	endtask
	task automatic bus(input logic w, input logic [6:0] a,
		input logic [7:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_write <= w;
		avs_read <= ~w;
		avs_writedata <= {24'h00_0000, d};
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 40);
		q = avs_readdata[7:0];
		if (n >= 40) n_fail++;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic t_reset();
		logic [6:0] ra[13] = '{`A_IIR, `A_LCR, `A_LSR, `A_TXLVL, `A_RXLVL,
			`A_IER, `A_FCR, `A_MCR, `A_EFR, `A_TCR, `A_TLR, `A_XFR, 7'h7C};
		logic [7:0] re[13] = '{8'h01, 8'h1D, 8'h60, 8'h40, 8'h00, 8'h00,
			8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		check({rts_n, irq_n, tx_permit, tx_flow_req}, 4'hE);
		check(line_ctrl, 8'h1D);
		for (int i = 0; i < 13; i++) begin
			bus(1'b0, ra[i], 8'h00);
			check(q, re[i]);
		end
		bus(1'b0, `A_MSR, 8'h00);
		check(q & 8'h0F, 8'h00);
	endtask
	task automatic t_keep(input logic sw);
		int d0;
		logic [7:0] fl[4] = '{8'hD1, 8'hC7, 8'hF3, 8'hE5};
		d0 = dp_cnt;
		wr(`A_LCR, 8'h03);
		wr(`A_EFR, 8'h40);
		wr(`A_MCR, 8'h22);
		if (sw) begin
			wr(`A_SPR, 8'hA5);
			wr(`A_DLL, 8'h34);
			wr(`A_DLH, 8'h12);
			for (int i = 0; i < 4; i++) wr(`A_XON1 + 7'(4 * i), fl[i]);
			wr(`A_SRST, 8'h08);
		end else begin
			rst_n <= 1'b0;
			tick(2);
			rst_n <= 1'b1;
		end
		tick(3);
		check(dp_cnt > d0, 1'b1);
		check(line_ctrl, 8'h1D);
		check(divisor, 16'h1234);
		check(rts_n, 1'b1);
		bus(1'b0, `A_SPR, 8'h00);
		check(q, 8'hA5);
		for (int i = 0; i < 4; i++) begin
			bus(1'b0, `A_XON1 + 7'(4 * i), 8'h00);
			check(q, fl[i]);
		end
		bus(1'b0, `A_EFR, 8'h00);
		check(q, 8'h00);
		bus(1'b0, `A_MCR, 8'h00);
		check(q, 8'h00);
	endtask
	task automatic t_rts(input logic [7:0] flow_threshold_reg, input logic [7:0] fifo_control_reg,
		input logic [6:0] h, input logic [6:0] r);
		wr(`A_TCR, flow_threshold_reg);
		wr(`A_FCR, fifo_control_reg);
		wr(`A_EFR, 8'h40);
		wr(`A_MCR, 8'h02);
		rx_level <= h - 7'd1;
		tick(6);
		check(rts_n, 1'b0);
		rx_level <= h;
		tick(6);
		check(rts_n, 1'b1);
		rx_level <= r + 7'd1;
		tick(6);
		check(rts_n, 1'b1);
		rx_level <= r;
		tick(6);
		check(rts_n, 1'b0);
		rx_level <= 7'd0;
		wr(`A_EFR, 8'h00);
	endtask
	task automatic t_cts();
		wr(`A_EFR, 8'h80);
		wr(`A_IER, 8'h08);
		far.set_cts(1'b1);
		tick(6);
		check(tx_permit, 1'b0);
		check(irq_n, 1'b1);
		far.set_cts(1'b0);
		tick(6);
		check(tx_permit, 1'b1);
		check(irq_n, 1'b1);
		wr(`A_EFR, 8'h00);
		wr(`A_IER, 8'h00);
	endtask
	task automatic wait_q(input int n);
		int k;
		k = 0;
		while (far.sent_q.size() < n && k < 100) begin
			@(posedge sys_clk);
			k++;
		end
		check(far.sent_q.size(), n);
	endtask
	task automatic t_swtx();
		logic [7:0] off[2] = '{8'hF3, 8'hE5};
		logic [7:0] on[2] = '{8'hD1, 8'hC7};
		logic [7:0] lc, mk;
		int nq, f;
		wr(`A_TCR, 8'h25);
		for (int m = 1; m <= 3; m++) begin
			lc = (m == 3) ? 8'h03 : 8'(m - 1);
			mk = 8'((9'h001 << (5 + lc)) - 9'h001);
			nq = (m == 3) ? 2 : 1;
			f = (m == 1) ? 1 : 0;
			wr(`A_LCR, lc);
			// only transmit flow bits, never with auto rts/cts
			wr(`A_EFR, 8'(m << 2));
			far.ack_delay = 3 * m - 3;
			far.sent_q.delete();
			rx_level <= 7'd21;
			wait_q(nq);
			for (int i = 0; i < nq; i++) begin
				check(far.sent_q[i], off[f + i] & mk);
			end
			rx_level <= 7'd8;
			wait_q(2 * nq);
			tick(10);
			check(far.sent_q.size(), 2 * nq);
			for (int i = 0; i < nq; i++) begin
				check(far.sent_q[nq + i], on[f + i] & mk);
			end
		end
		rx_level <= 7'd0;
		wr(`A_EFR, 8'h00);
		wr(`A_LCR, 8'h03);
	endtask
	task automatic rx_step(input logic [7:0] ch, input logic e);
		far.send(ch);
		tick(4);
		check(tx_permit, e);
		check(irq_n, e);
	endtask
	task automatic t_swrx();
		wr(`A_IER, 8'h20);
		wr(`A_EFR, 8'h02);
		rx_step(8'hE5, 1'b1);
		rx_step(8'hF3, 1'b0);
		bus(1'b0, `A_IIR, 8'h00);
		check(q & 8'h10, 8'h10);
		rx_step(8'hD1, 1'b1);
		wr(`A_EFR, 8'h01);
		rx_step(8'hF3, 1'b1);
		rx_step(8'hE5, 1'b0);
		rx_step(8'hD1, 1'b0);
		rx_step(8'hC7, 1'b1);
		// one transmit pair: either receive pair counts
		wr(`A_EFR, 8'h0B);
		rx_step(8'hE5, 1'b0);
		rx_step(8'hD1, 1'b1);
		// both transmit pairs: receive needs the full sequence
		wr(`A_EFR, 8'h0F);
		rx_step(8'hE5, 1'b1);
		rx_step(8'hF3, 1'b1);
		rx_step(8'hE5, 1'b0);
		rx_step(8'hC7, 1'b0);
		rx_step(8'hD1, 1'b0);
		rx_step(8'hC7, 1'b1);
		wr(`A_EFR, 8'h02);
		wr(`A_MCR, 8'h20);
		rx_step(8'hF3, 1'b0);
		far.send(8'h41);
		tick(4);
		check(tx_permit, 1'b1);
		check(irq_n, 1'b0);
		rx_step(8'hD1, 1'b1);
		wr(`A_MCR, 8'h00);
	endtask
	task automatic t_spec();
		wr(`A_EFR, 8'h20);
		far.send(8'hE5);
		tick(4);
		check(tx_permit, 1'b1);
		check(irq_n, 1'b0);
		bus(1'b0, `A_IIR, 8'h00);
		check(q & 8'h10, 8'h10);
		tick(3);
		check(irq_n, 1'b1);
		wr(`A_EFR, 8'h00);
		wr(`A_IER, 8'h00);
	endtask
	initial begin
		rst_n = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 7'h00;
		avs_writedata = 32'h0000_0000;
		rx_level = 7'd0;
		tx_level = 7'd0;
		tick(10);
		rst_n <= 1'b1;
		tick(1);
		t_reset();
		t_keep(1'b1);
		t_keep(1'b0);
		t_rts(8'h25, 8'h00, 7'd20, 7'd8);
		t_rts(8'h00, 8'h41, 7'd16, 7'd8);
		t_cts();
		t_swtx();
		t_swrx();
		t_spec();
		end_of_test();
	end
endmodule
`default_nettype wire
